/* File: clp_pkg.sv */
// package for the command list processor: register map, opcodes, field positions, status bit layout
// assumes a 32-bit avalon-mm slave port and simple request/ack masters for memory and register space
// Function
// - writing run_flag one starts fetching at the program-address field
// - run_flag reads one while running; clearing it halts after current command
// - setting run_flag again restarts at the written program-address field
// - idle bit 30 reads one when idle, zero when busy, resets to one
// - 28-bit pc tracks current command, three low bits are zero
// - control register reads live pc; software rewrites pc before restart
// - halting at conditional jump leaves pc at taken or fall-through address
// - 32-bit condition register; jump taken when mask and condition share bits
// - call saves next address in read-only return pointer; return resumes there
// - decode 4-bit opcode in bits 31:28 into loads, test and flow commands
// - memory load writes 32 bits, or 16 bits from 47:32 when width bit set
// - bits 63:62 are byte enables for 16-bit memory loads
// - single memory load destination has four low address bits forced zero
// - register load writes bits 63:32 to register space, low two bits zero
// - immediate loads write count inline words to consecutive destinations
// - indirect memory load copies counted words from source to destination memory
// - indirect register load copies counted words from memory into registers
// - status test stalls while masked hardware status differs from masked expected
// - status sources cover fifo empties, busy bits, layers, field and syncs
// - halt command clears run_flag and optionally raises list interrupt status
// - branch and call targets are relative to current command or absolute
// - taken conditional jump adds signed offset to next command address
// - flow commands flush the prefetched command fifo
package clp_pkg;
    localparam logic [7:0]  CLP_OFS_CTRL  = 8'h18;
    localparam logic [7:0]  CLP_OFS_COND  = 8'h1C;
    localparam logic [7:0]  CLP_OFS_RET   = 8'h20;
    localparam int          CLP_RUN_BIT   = 31;
    localparam int          CLP_IDLE_BIT  = 30;
    localparam int          CLP_PC_W      = 28;
    localparam logic [3:0]  OP_LD_MEM     = 4'h0;
    localparam logic [3:0]  OP_LD_REG     = 4'h1;
    localparam logic [3:0]  OP_LD_MEM_IMM = 4'h2;
    localparam logic [3:0]  OP_LD_REG_IMM = 4'h3;
    localparam logic [3:0]  OP_LD_MEM_IND = 4'h4;
    localparam logic [3:0]  OP_LD_REG_IND = 4'h5;
    localparam logic [3:0]  OP_STAT_TEST  = 4'h6;
    localparam logic [3:0]  OP_HALT       = 4'h8;
    localparam logic [3:0]  OP_BRANCH     = 4'h9;
    localparam logic [3:0]  OP_CALL       = 4'hA;
    localparam logic [3:0]  OP_RETURN     = 4'hB;
    localparam logic [3:0]  OP_COND_JUMP  = 4'hC;
    localparam int          STAT_W        = 21;
    localparam logic [31:0] RELATIVE_MASK = 32'h0000_0001;
    localparam logic [31:0] MEMLD_WIDTH   = 32'h0000_0001;
    localparam logic [31:0] HALT_IRQ_MASK = 32'h0000_0001;
    localparam logic [27:0] ALIGN64_MASK  = 28'hFFFFFF8;
    localparam logic [27:0] ALIGN128_MASK = 28'hFFFFFF0;
    localparam logic [27:0] ALIGN32_MASK  = 28'hFFFFFFC;
    localparam logic [27:0] REG_SPACE_MSK = 28'h01FFFFC;
    localparam logic [27:0] ENTRY_STEP    = 28'h0000008;
    localparam logic [27:0] WORD_STEP     = 28'h0000004;

    // memory / register space write request
    typedef struct packed {
        logic        to_reg;   // 1: register space, 0: memory
        logic [27:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } clp_wr_t;

    // hardware status inputs in mask bit order
    typedef struct packed {
        logic draw_mem_fifo_empty;  // 20
        logic host_cmd_fifo_empty;  // 19
        logic color_conv_busy;      // 18
        logic mem_dma_busy;         // 17
        logic crt_layer_state;      // 16
        logic video_field_parity;   // 15
        logic video_layer_state;    // 14
        logic panel_layer_state;    // 13
        logic analog_vsync;         // 12
        logic panel_vsync;          // 11
        logic setup_engine_busy;    // 2
        logic draw_cmd_fifo_empty;  // 1
        logic draw_engine_busy;     // 0
    } clp_stat_t;
endpackage : clp_pkg

/* File: clp_core.sv */
// command list processor: avalon-mm registers, fetch, decode and execute of list entries
// assumes memory reads/writes and register writes answer with a one-cycle ack; status inputs are synchronous
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module clp_core
    import clp_pkg::*;
(
    input  wire logic        core_clk,        // 125 MHz system clock
    input  wire logic        rst_b,           // synchronous reset, active low
    input  wire logic [7:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read strobe
    input  wire logic        avs_write,       // write strobe
    input  wire logic [31:0] avs_writedata,   // write data
    input  wire logic [3:0]  avs_byteenable,  // byte lanes
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // stall
    output logic             mrd_req,         // memory read request
    output logic      [27:0] mrd_addr,        // memory read address
    input  wire logic        mrd_ack,         // memory read done
    input  wire logic [31:0] mrd_data,        // memory read data
    output logic             wr_req,          // write request
    output clp_wr_t          wr_cmd,          // write target and data
    input  wire logic        wr_ack,          // write done
    input  wire clp_stat_t   hw_status,       // engine status sources
    output logic             list_irq_set     // one-cycle halt interrupt event
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_EXEC, S_WRITE, S_IMM_RD, S_SRC_RD, S_CNT_RD, S_DST_RD, S_XFER_RD, S_WAIT
    } clp_state_t;

    clp_state_t  state_reg,   state_next;
    logic        run_reg;
    logic [27:0] pc_reg;
    logic [31:0] cond_reg;
    logic [27:0] ret_reg;
    logic [63:0] cmd_reg;
    logic [1:0]  fcnt_reg;      // fetch word index
    logic [31:0] cnt_reg;
    logic [27:0] src_reg;
    logic [27:0] dst_reg;
    logic        to_reg_reg;
    logic        wr_req_reg;
    clp_wr_t     wr_cmd_reg;
    logic        irq_reg;
    logic [31:0] rdata_reg;
    logic        rack_reg;
    logic        mrd_req_reg;
    logic [27:0] mrd_addr_reg;

    function automatic logic [27:0] add_pc(input logic [27:0] a, input logic [27:0] b);
        add_pc = (a + b) & ALIGN64_MASK;
    endfunction : add_pc

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire         sel_ctrl  = (avs_address == CLP_OFS_CTRL);
    wire         sel_cond  = (avs_address == CLP_OFS_COND);
    wire         sel_ret   = (avs_address == CLP_OFS_RET);
    wire         wr_ctrl   = avs_write && sel_ctrl && avs_byteenable[3];
    wire         run_wr1   = wr_ctrl && avs_writedata[CLP_RUN_BIT];
    wire         run_wr0   = wr_ctrl && !avs_writedata[CLP_RUN_BIT];
    wire         idle      = (state_reg == S_IDLE);
    wire [31:0]  ctrl_rd   = {run_reg, idle, 2'b00, pc_reg & ALIGN64_MASK};
    wire [31:0]  rd_mux    = sel_ctrl ? ctrl_rd :
                             sel_cond ? cond_reg :
                             sel_ret  ? {4'h0, ret_reg & ALIGN64_MASK} : 32'h0000_0000;
    wire [31:0]  be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // reads answer one cycle after the strobe, writes at once
    assign avs_waitrequest = avs_read && !rack_reg;
    assign avs_readdata    = rdata_reg;

    // ------------------------------------------------------------
    // decode of current entry
    // ------------------------------------------------------------
    wire [3:0]   opc       = cmd_reg[31:28];
    wire [27:0]  fld       = cmd_reg[27:0];
    wire [27:0]  next_pc   = add_pc(pc_reg, ENTRY_STEP);
    // count beyond 2^26 words wraps the 28-bit space anyway, so the part-select loses nothing
    wire [27:0]  imm_end   = add_pc(next_pc, {cmd_reg[57:32], 2'b00} + WORD_STEP);
    wire [27:0]  rel_tgt   = add_pc(pc_reg, fld);
    wire [27:0]  abs_tgt   = fld & ALIGN64_MASK;
    wire [27:0]  br_tgt    = (|(cmd_reg[31:0] & RELATIVE_MASK)) ? rel_tgt : abs_tgt;
    wire         jmp_take  = |(cmd_reg[63:32] & cond_reg);
    wire [27:0]  jmp_tgt   = jmp_take ? add_pc(next_pc, fld) : next_pc;
    wire [20:0]  stat_vec  = {hw_status[12:3], 8'h00, hw_status[2:0]};
    wire [20:0]  stat_mask = cmd_reg[20:0];
    wire         stat_ok   = ((stat_vec & stat_mask) == (cmd_reg[52:32] & stat_mask));
    wire         is_w16    = |(cmd_reg[31:0] & MEMLD_WIDTH);
    wire [3:0]   ld_be     = is_w16 ? {2'b00, cmd_reg[63], cmd_reg[62]} : 4'hF;
    wire [31:0]  ld_data   = is_w16 ? {16'h0000, cmd_reg[47:32]} : cmd_reg[63:32];
    wire         flow      = opc[3];

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cond_reg  <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            rack_reg  <= 1'b0;
        end
        else
        begin
            rack_reg  <= avs_read && !rack_reg;
            rdata_reg <= rd_mux;
            if (avs_write && sel_cond)
                cond_reg <= (cond_reg & ~be_mask) | (avs_writedata & be_mask);
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE:    if (run_reg) state_next = S_FETCH;
            S_FETCH:   if (mrd_ack && fcnt_reg == 2'd1) state_next = S_EXEC;
            S_EXEC:    state_next = S_FETCH;
            S_WRITE:   if (wr_ack) state_next = S_FETCH;
            S_IMM_RD:  if (mrd_ack) state_next = S_WRITE;
            S_SRC_RD, S_CNT_RD, S_DST_RD, S_XFER_RD: if (mrd_ack) state_next = S_WRITE;
            S_WAIT:    if (stat_ok) state_next = S_FETCH;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_reg    <= S_IDLE;
            run_reg      <= 1'b0;
            pc_reg       <= 28'h0000000;
            ret_reg      <= 28'h0000000;
            cmd_reg      <= 64'h0000_0000_0000_0000;
            fcnt_reg     <= 2'd0;
            cnt_reg      <= 32'h0000_0000;
            src_reg      <= 28'h0000000;
            dst_reg      <= 28'h0000000;
            to_reg_reg   <= 1'b0;
            wr_req_reg   <= 1'b0;
            wr_cmd_reg   <= '0;
            irq_reg      <= 1'b0;
            mrd_req_reg  <= 1'b0;
            mrd_addr_reg <= 28'h0000000;
        end
        else
        begin
            irq_reg <= 1'b0;
            if (run_wr1 && state_reg == S_IDLE)
            begin
                run_reg <= 1'b1;
                pc_reg  <= avs_writedata[27:0] & ALIGN64_MASK;
            end
            else if (run_wr0)
                run_reg <= 1'b0;
            unique case (state_reg)
                S_IDLE:
                begin
                    fcnt_reg <= 2'd0;
                    if (run_reg)
                    begin
                        mrd_req_reg  <= 1'b1;
                        mrd_addr_reg <= pc_reg;
                        state_reg    <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    if (!run_reg && fcnt_reg == 2'd0 && !mrd_req_reg)
                        state_reg <= S_IDLE;
                    else if (!mrd_req_reg && fcnt_reg == 2'd0)
                    begin
                        mrd_req_reg  <= 1'b1;
                        mrd_addr_reg <= pc_reg;
                    end
                    else if (mrd_ack)
                    begin
                        // low word then high word; no prefetch beyond the entry, so flush is implicit
                        if (fcnt_reg == 2'd0)
                        begin
                            cmd_reg[31:0] <= mrd_data;
                            mrd_addr_reg  <= mrd_addr_reg + WORD_STEP;
                            fcnt_reg      <= 2'd1;
                        end
                        else
                        begin
                            cmd_reg[63:32] <= mrd_data;
                            mrd_req_reg    <= 1'b0;
                            fcnt_reg       <= 2'd0;
                            state_reg      <= state_next;
                        end
                    end
                end
                S_EXEC:
                begin
                    state_reg <= S_FETCH;
                    unique case (opc)
                        OP_LD_MEM, OP_LD_REG:
                        begin
                            wr_req_reg <= 1'b1;
                            if (opc == OP_LD_MEM)
                                wr_cmd_reg <= '{1'b0, fld & ALIGN128_MASK, ld_data, ld_be};
                            else
                                wr_cmd_reg <= '{1'b1, fld & REG_SPACE_MSK, cmd_reg[63:32], 4'hF};
                            cnt_reg    <= 32'h0000_0000;
                            pc_reg     <= next_pc;
                            state_reg  <= S_WRITE;
                        end
                        OP_LD_MEM_IMM, OP_LD_REG_IMM:
                        begin
                            // inline words follow the entry; software pads odd counts
                            cnt_reg    <= cmd_reg[63:32];
                            to_reg_reg <= opc[0];
                            dst_reg    <= opc[0] ? (fld & REG_SPACE_MSK) : (fld & ALIGN32_MASK);
                            src_reg    <= next_pc;
                            pc_reg     <= imm_end;
                            if (cmd_reg[63:32] != 32'h0000_0000)
                            begin
                                mrd_req_reg  <= 1'b1;
                                mrd_addr_reg <= next_pc;
                                state_reg    <= S_IMM_RD;
                            end
                        end
                        OP_LD_MEM_IND, OP_LD_REG_IND:
                        begin
                            // 128-bit entry: fetch source address and count words
                            to_reg_reg   <= opc[0];
                            dst_reg      <= opc[0] ? (fld & REG_SPACE_MSK) : (fld & ALIGN32_MASK);
                            mrd_req_reg  <= 1'b1;
                            mrd_addr_reg <= next_pc;
                            state_reg    <= S_SRC_RD;
                        end
                        OP_STAT_TEST:
                        begin
                            pc_reg    <= next_pc;
                            state_reg <= S_WAIT;
                        end
                        OP_HALT:
                        begin
                            run_reg   <= 1'b0;
                            irq_reg   <= |(cmd_reg[31:0] & HALT_IRQ_MASK);
                            pc_reg    <= next_pc;
                            state_reg <= S_IDLE;
                        end
                        OP_BRANCH:    pc_reg <= br_tgt;
                        OP_CALL:
                        begin
                            ret_reg <= next_pc;
                            pc_reg  <= br_tgt;
                        end
                        OP_RETURN:    pc_reg <= ret_reg & ALIGN64_MASK;
                        OP_COND_JUMP: pc_reg <= jmp_tgt;
                        default:      pc_reg <= next_pc;
                    endcase
                end
                S_SRC_RD:
                    if (mrd_ack)
                    begin
                        src_reg      <= mrd_data[27:0] & ALIGN32_MASK;
                        mrd_addr_reg <= mrd_addr_reg + WORD_STEP;
                        state_reg    <= S_CNT_RD;
                    end
                S_CNT_RD:
                    if (mrd_ack)
                    begin
                        cnt_reg <= mrd_data;
                        pc_reg  <= add_pc(next_pc, ENTRY_STEP);
                        if (mrd_data == 32'h0000_0000)
                        begin
                            mrd_req_reg <= 1'b0;
                            state_reg   <= S_FETCH;
                        end
                        else
                        begin
                            mrd_addr_reg <= src_reg;
                            state_reg    <= S_XFER_RD;
                        end
                    end
                S_IMM_RD, S_XFER_RD:
                    if (mrd_ack)
                    begin
                        mrd_req_reg <= 1'b0;
                        wr_req_reg  <= 1'b1;
                        wr_cmd_reg  <= '{to_reg_reg, dst_reg, mrd_data, 4'hF};
                        cnt_reg     <= cnt_reg - 32'h0000_0001;
                        src_reg     <= src_reg + WORD_STEP;
                        dst_reg     <= dst_reg + WORD_STEP;
                        state_reg   <= S_WRITE;
                    end
                S_WRITE:
                    if (wr_ack)
                    begin
                        wr_req_reg <= 1'b0;
                        if (cnt_reg == 32'h0000_0000)
                        begin
                            // pc already points past the 64-bit entry, the inline words or the 128-bit entry
                            state_reg <= S_FETCH;
                        end
                        else
                        begin
                            mrd_req_reg  <= 1'b1;
                            mrd_addr_reg <= src_reg;
                            state_reg    <= S_XFER_RD;
                        end
                    end
                S_WAIT:
                    if (stat_ok)
                        state_reg <= S_FETCH;
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    assign mrd_req      = mrd_req_reg;
    assign mrd_addr     = mrd_addr_reg;
    assign wr_req       = wr_req_reg;
    assign wr_cmd       = wr_cmd_reg;
    assign list_irq_set = irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence halt_exec_s;
        state_reg == S_EXEC && opc == OP_HALT;
    endsequence

    idle_bit_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ctrl_rd[CLP_IDLE_BIT] == (state_reg == S_IDLE))
        else $error("idle bit wrong");
    pc_aligned_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        pc_reg[2:0] == 3'b000 && ret_reg[2:0] == 3'b000)
        else $error("pc not aligned");
    halt_clears_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        halt_exec_s |=> !run_reg && state_reg == S_IDLE)
        else $error("halt did not stop");
    call_saves_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == S_EXEC && opc == OP_CALL |=> ret_reg == $past(next_pc))
        else $error("return address wrong");
    jump_target_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == S_EXEC && opc == OP_COND_JUMP && !jmp_take |=> pc_reg == $past(next_pc))
        else $error("jump fell wrong");
    stat_stall_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == S_WAIT && !stat_ok |=> state_reg == S_WAIT)
        else $error("status test did not stall");
    memld_align_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == S_EXEC && opc == OP_LD_MEM |=> wr_cmd_reg.addr[3:0] == 4'h0)
        else $error("memory load not aligned");
    reserved_nop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == S_EXEC && (opc == 4'h7 || opc >= 4'hD) |=> pc_reg == $past(next_pc) && !wr_req_reg)
        else $error("reserved opcode acted");
endmodule : clp_core

/* File: clp_mem_model.sv */
// memory and register-space partner for the command list processor
// assumes each request is held until its one-cycle ack
`timescale 1ns/1ps
module clp_mem_model
    import clp_pkg::*;
(
    input  wire logic        core_clk, // system clock
    input  wire logic        mrd_req,  // read request
    input  wire logic [27:0] mrd_addr, // read address
    output logic             mrd_ack,  // read done
    output logic      [31:0] mrd_data, // read data
    input  wire logic        wr_req,   // write request
    output logic             wr_ack    // write done
);
    logic [31:0] mem [0:63];
    initial
    begin
        mrd_ack = 1'b0;
        wr_ack = 1'b0;
        mrd_data = 32'h0;
    end
    // data off the ack cycle is inverted so stale values never look valid
    always @(posedge core_clk)
    begin
        mrd_ack <= mrd_req && !mrd_ack;
        wr_ack <= wr_req && !wr_ack;
        mrd_data <= (mrd_req && !mrd_ack) ? mem[mrd_addr[7:2]] : ~mrd_data;
    end
endmodule : clp_mem_model

/* File: command_list_processor_test.sv */
// self-checking bench for clp_core: avalon-mm register access and two short lists
// assumes clp_mem_model answers memory and register-space requests
`timescale 1ns/1ps
module command_list_processor_test
    import clp_pkg::*;
;
    logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, mrd_req, mrd_ack, wr_req, wr_ack, list_irq_set;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, mrd_data, q;
    logic [27:0] mrd_addr;
    clp_wr_t     wr_cmd;
    clp_stat_t   hw_status;
    clp_wr_t     wlog[$];
    int          miscompares, n_compared, irqs;
    clp_core i_clp_core (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mrd_req(mrd_req), .mrd_addr(mrd_addr), .mrd_ack(mrd_ack),
        .mrd_data(mrd_data), .wr_req(wr_req), .wr_cmd(wr_cmd), .wr_ack(wr_ack), .hw_status(hw_status),
        .list_irq_set(list_irq_set));
    clp_mem_model i_clp_mem_model (.core_clk(core_clk), .mrd_req(mrd_req), .mrd_addr(mrd_addr),
        .mrd_ack(mrd_ack), .mrd_data(mrd_data), .wr_req(wr_req), .wr_ack(wr_ack));
    task automatic give_verdict;
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one idle edge first so a release and a new strobe never share a time step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
        begin
            miscompares++;
            give_verdict();
        end
    endtask : bus
    always @(posedge core_clk)
    begin
        if (wr_req === 1'b1 && wr_ack === 1'b1)
            wlog.push_back(wr_cmd);
        if (list_irq_set === 1'b1)
            irqs++;
    end
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
        hw_status = '0;
        // list at 0x40: memory load, reserved entry, register load, halt with interrupt
        i_clp_mem_model.mem[16:23] = '{32'h0000_0122, 32'h1234_5678, 32'h7000_0000, 32'h0,
                                       32'h1000_0107, 32'hA5A5_0001, 32'h8000_0001, 32'h0};
        // list at 0x80: immediate load of one word plus pad, taken jump over a register load, quiet halt
        i_clp_mem_model.mem[32:41] = '{32'h2000_0200, 32'h0000_0001, 32'hCAFE_0001, 32'h0,
                                       32'hC000_0008, 32'h0000_0001, 32'h1000_0300, 32'hDEAD_0000,
                                       32'h8000_0000, 32'h0};
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        bus(0, CLP_OFS_CTRL, 0, q); check("ctrl reset", 32'h4000_0000, q);
        bus(1, CLP_OFS_COND, 32'hA5A5_0F0F, q);
        bus(0, CLP_OFS_COND, 0, q); check("cond", 32'hA5A5_0F0F, q);
        bus(0, 8'h40, 0, q); check("unmapped", 32'h0, q);
        bus(1, CLP_OFS_CTRL, 32'h8000_0040, q);
        bus(0, CLP_OFS_CTRL, 0, q); check("running", 2'b10, q[31:30]);
        for (int n = 0; n < 200 && irqs == 0; n++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        check("irq", 1, irqs);
        check("writes", 2, wlog.size());
        check("mem addr", 32'h120, {4'h0, wlog[0].addr});
        check("mem data", 32'h1234_5678, wlog[0].data);
        check("mem to_reg", 1'b0, wlog[0].to_reg);
        check("reg addr", 32'h104, {4'h0, wlog[1].addr});
        check("reg data", 32'hA5A5_0001, wlog[1].data);
        check("reg to_reg", 1'b1, wlog[1].to_reg);
        bus(0, CLP_OFS_CTRL, 0, q); check("halted", 2'b01, q[31:30]);
        check("pc align", 3'b000, q[2:0]);
        bus(1, CLP_OFS_CTRL, 32'h8000_0080, q);
        for (int n = 0; n < 300 && wlog.size() < 3; n++) @(posedge core_clk);
        repeat (30) @(posedge core_clk);
        check("writes 2", 3, wlog.size());
        check("imm addr", 32'h200, {4'h0, wlog[2].addr});
        check("imm data", 32'hCAFE_0001, wlog[2].data);
        check("irq 2", 1, irqs);
        bus(0, CLP_OFS_CTRL, 0, q); check("halt pc", 32'h4000_00A8, q);
        give_verdict();
    end
endmodule : command_list_processor_test
